// >>> core/tc2_irq_pkg.sv
// package for the timer-2 interrupt and asynchronous-status block
// assumes a cpu data-space register port with byte-wide data
package tc2_irq_pkg;
  localparam logic [7:0] flags_data_addr = 8'h37;
  localparam logic [7:0] io_space_offset = 8'h20;
  localparam logic [7:0] flags_io_addr = 8'h17;
  localparam logic [7:0] mask_addr = 8'h70;
  localparam logic [7:0] async_addr = 8'hb6;
  localparam logic [7:0] ctrl_a_addr = 8'hb0;
  localparam logic [7:0] ctrl_b_addr = 8'hb1;
  localparam logic [7:0] counter_addr = 8'hb2;
  localparam logic [7:0] cmp_a_addr = 8'hb3;
  localparam logic [7:0] cmp_b_addr = 8'hb4;
  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [7:0] count_max = 8'hff;
  localparam logic [7:0] count_bottom = 8'h00;
  localparam int bit_ovf = 0;
  localparam int bit_cmp_a = 1;
  localparam int bit_cmp_b = 2;
  localparam int irq_bits = 3;
  localparam int bit_ctrl_b_busy = 0;
  localparam int bit_ctrl_a_busy = 1;
  localparam int bit_cmp_b_busy = 2;
  localparam int bit_cmp_a_busy = 3;
  localparam int bit_counter_busy = 4;
  localparam int bit_async_sel = 5;
  localparam int bit_ext_clk = 6;
  localparam int busy_bits = 5;
  localparam logic [2:0] async_sync_cycles = 3'h2;
endpackage : tc2_irq_pkg

// >>> core/tc2_update_slot.sv
// one asynchronously updated register with its temporary holding copy
// assumes the transfer delay models the slow-clock hand-over
`timescale 1ns/1ps
module tc2_update_slot (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wr,
  input wire logic async_mode,
  input wire logic [7:0] wdata,
  output logic [7:0] value_reg,
  output logic busy_reg
);
  logic [7:0] hold_reg;
  logic [2:0] wait_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      value_reg <= tc2_irq_pkg::reg_reset;
      hold_reg <= tc2_irq_pkg::reg_reset;
      busy_reg <= 1'b0;
      wait_reg <= 3'h0;
    end else if (wr && async_mode) begin
      // staged; the target loads only after the hand-over delay
      hold_reg <= wdata;
      busy_reg <= 1'b1;
      wait_reg <= tc2_irq_pkg::async_sync_cycles;
    end else if (wr) begin
      value_reg <= wdata;
    end else if (busy_reg) begin
      if (wait_reg == 3'h0) begin
        value_reg <= hold_reg;
        busy_reg <= 1'b0;
      end else begin
        wait_reg <= wait_reg - 3'h1;
      end
    end
  end
endmodule : tc2_update_slot

// >>> core/tc2_irq_status.sv
// timer-2 interrupt mask, interrupt flags and asynchronous status
// assumes a byte-wide cpu register port; counter core supplies events
//
// Contract
// - compare-B value compared to counter continuously
// - compare-B request needs enable, global bit, flag
// - compare-A request needs enable, global bit, flag
// - overflow request needs enable, global bit, flag
// - compare-B match sets flag bit two
// - compare-A match sets flag bit one
// - counter overflow sets flag bit zero
// - pwm direction change at bottom sets overflow
// - vector execution clears its flag
// - writing one clears flag, zero keeps
// - external clock buffer enabled; crystal off then
// - async select chooses i/o or oscillator clock
// - counter write sets busy until loaded
// - compare-A write sets busy until loaded
// - compare-B write sets busy until loaded
// - control-A write sets busy until transferred
// - control-B write sets busy until transferred
// - flags at data 0x37 and io 0x17
`timescale 1ns/1ps
module tc2_irq_status (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic io_space,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic global_irq_enable,
  input wire logic [7:0] counter_value,
  input wire logic counter_overflow,
  input wire logic pwm_mode,
  input wire logic pwm_bottom_turn,
  input wire logic [tc2_irq_pkg::irq_bits-1:0] vector_ack,
  output logic [tc2_irq_pkg::irq_bits-1:0] irq_req,
  output logic cmp_b_match,
  output logic ext_clock_input_enable,
  output logic crystal_osc_run,
  output logic timer_clk_async,
  output logic [7:0] compare_a_value,
  output logic [7:0] compare_b_value,
  output logic [7:0] timer_ctrl_a,
  output logic [7:0] timer_ctrl_b,
  output logic [7:0] counter_load_value,
  output logic counter_load
);
  localparam int irq_n = tc2_irq_pkg::irq_bits;

  logic [7:0] eff_addr;
  logic wr_flags;
  logic wr_mask;
  logic wr_async;
  logic [irq_n-1:0] tc2_irq_flags_reg;
  logic [irq_n-1:0] tc2_irq_flags_next;
  logic [irq_n-1:0] tc2_irq_mask_reg;
  logic [irq_n-1:0] hw_set;
  logic [1:0] async_ctl_reg;
  logic [tc2_irq_pkg::busy_bits-1:0] busy;
  logic [tc2_irq_pkg::busy_bits-1:0] wr_slot;
  logic [7:0] slot_val [tc2_irq_pkg::busy_bits];
  logic [7:0] rdata_next;
  logic async_mode;
  logic cnt_busy_d_reg;
  logic [irq_n-1:0] vec_clear;
  logic [irq_n-1:0] sw_clear;
  logic [irq_n-1:0] irq_gate;

  // io instructions address the low window; rebase onto data space
  always_comb begin
    if (io_space) begin
      eff_addr = 8'(addr + tc2_irq_pkg::io_space_offset);
    end else begin
      eff_addr = addr;
    end
  end

  assign wr_flags = wr_en && (eff_addr == tc2_irq_pkg::flags_data_addr);
  assign wr_mask = wr_en && (eff_addr == tc2_irq_pkg::mask_addr);
  assign wr_async = wr_en && (eff_addr == tc2_irq_pkg::async_addr);
  assign async_mode = async_ctl_reg[1];

  // compare values come from the update slots, so matches use loaded values
  always_comb begin
    hw_set = '0;
    hw_set[tc2_irq_pkg::bit_cmp_b] =
      (counter_value == slot_val[tc2_irq_pkg::bit_cmp_b_busy]);
    hw_set[tc2_irq_pkg::bit_cmp_a] =
      (counter_value == slot_val[tc2_irq_pkg::bit_cmp_a_busy]);
    hw_set[tc2_irq_pkg::bit_ovf] = pwm_mode ? pwm_bottom_turn
                                            : counter_overflow;
  end

  // both clear paths are plain masks; the set term is ored in after them
  assign vec_clear = vector_ack;
  assign sw_clear = wr_flags ? wdata[irq_n-1:0] : '0;

  always_comb begin
    tc2_irq_flags_next = tc2_irq_flags_reg & ~vec_clear;
    tc2_irq_flags_next = tc2_irq_flags_next & ~sw_clear;
    // set last so a coincident clear never drops an event
    tc2_irq_flags_next = tc2_irq_flags_next | hw_set;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tc2_irq_flags_reg <= '0;
    end else begin
      tc2_irq_flags_reg <= tc2_irq_flags_next;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tc2_irq_mask_reg <= '0;
    end else if (wr_mask) begin
      tc2_irq_mask_reg <= wdata[irq_n-1:0];
    end
  end

  // a request needs its flag, its enable bit and the cpu global bit together
  always_comb begin
    irq_gate = '0;
    irq_gate[tc2_irq_pkg::bit_cmp_b] = tc2_irq_flags_next[tc2_irq_pkg::bit_cmp_b]
      && tc2_irq_mask_reg[tc2_irq_pkg::bit_cmp_b] && global_irq_enable;
    irq_gate[tc2_irq_pkg::bit_cmp_a] = tc2_irq_flags_next[tc2_irq_pkg::bit_cmp_a]
      && tc2_irq_mask_reg[tc2_irq_pkg::bit_cmp_a] && global_irq_enable;
    irq_gate[tc2_irq_pkg::bit_ovf] = tc2_irq_flags_next[tc2_irq_pkg::bit_ovf]
      && tc2_irq_mask_reg[tc2_irq_pkg::bit_ovf] && global_irq_enable;
  end

  // requests registered from the next flag state; vector ack drops them next edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_req <= '0;
    end else begin
      irq_req <= irq_gate;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmp_b_match <= 1'b0;
    end else begin
      cmp_b_match <= hw_set[tc2_irq_pkg::bit_cmp_b];
    end
  end

  // [0] external clock bit, [1] async select; busy bits are read only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      async_ctl_reg <= 2'b00;
    end else if (wr_async) begin
      async_ctl_reg <= {wdata[tc2_irq_pkg::bit_async_sel],
                        wdata[tc2_irq_pkg::bit_ext_clk]};
    end
  end

  // buffer and crystal share the oscillator pin, so they never run together
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_clock_input_enable <= 1'b0;
    end else begin
      ext_clock_input_enable <= async_ctl_reg[0] && async_ctl_reg[1];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      crystal_osc_run <= 1'b0;
    end else begin
      crystal_osc_run <= async_ctl_reg[1] && !async_ctl_reg[0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timer_clk_async <= 1'b0;
    end else begin
      timer_clk_async <= async_ctl_reg[1];
    end
  end

  // one-hot write strobe per slot; at most one address matches
  always_comb begin
    wr_slot = '0;
    if (wr_en) begin
      case (eff_addr)
        tc2_irq_pkg::ctrl_b_addr: wr_slot[tc2_irq_pkg::bit_ctrl_b_busy] = 1'b1;
        tc2_irq_pkg::ctrl_a_addr: wr_slot[tc2_irq_pkg::bit_ctrl_a_busy] = 1'b1;
        tc2_irq_pkg::cmp_b_addr: wr_slot[tc2_irq_pkg::bit_cmp_b_busy] = 1'b1;
        tc2_irq_pkg::cmp_a_addr: wr_slot[tc2_irq_pkg::bit_cmp_a_busy] = 1'b1;
        tc2_irq_pkg::counter_addr: wr_slot[tc2_irq_pkg::bit_counter_busy] = 1'b1;
        default: wr_slot = '0;
      endcase
    end
  end

  // busy bit index doubles as slot index; a write while busy restarts it
  genvar gi;
  generate
    for (gi = 0; gi < tc2_irq_pkg::busy_bits; gi++) begin : g_slot
      tc2_update_slot u_slot (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr(wr_slot[gi]),
        .async_mode(async_mode),
        .wdata(wdata),
        .value_reg(slot_val[gi]),
        .busy_reg(busy[gi])
      );
    end
  endgenerate

  // loaded values are re-registered so every top output leaves a flip-flop;
  // they trail the slot by one cycle, the match logic uses the slot directly
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      compare_a_value <= tc2_irq_pkg::reg_reset;
    end else begin
      compare_a_value <= slot_val[tc2_irq_pkg::bit_cmp_a_busy];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      compare_b_value <= tc2_irq_pkg::reg_reset;
    end else begin
      compare_b_value <= slot_val[tc2_irq_pkg::bit_cmp_b_busy];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timer_ctrl_a <= tc2_irq_pkg::reg_reset;
    end else begin
      timer_ctrl_a <= slot_val[tc2_irq_pkg::bit_ctrl_a_busy];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timer_ctrl_b <= tc2_irq_pkg::reg_reset;
    end else begin
      timer_ctrl_b <= slot_val[tc2_irq_pkg::bit_ctrl_b_busy];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      counter_load_value <= tc2_irq_pkg::reg_reset;
    end else begin
      counter_load_value <= slot_val[tc2_irq_pkg::bit_counter_busy];
    end
  end

  // counter load pulses when a sync write lands or the async busy falls
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_busy_d_reg <= 1'b0;
      counter_load <= 1'b0;
    end else begin
      cnt_busy_d_reg <= busy[tc2_irq_pkg::bit_counter_busy];
      counter_load <= (wr_slot[tc2_irq_pkg::bit_counter_busy] && !async_mode)
                      || (cnt_busy_d_reg && !busy[tc2_irq_pkg::bit_counter_busy]);
    end
  end

  always_comb begin
    rdata_next = tc2_irq_pkg::reg_reset;
    case (eff_addr)
      tc2_irq_pkg::flags_data_addr: rdata_next[irq_n-1:0] = tc2_irq_flags_reg;
      tc2_irq_pkg::mask_addr: rdata_next[irq_n-1:0] = tc2_irq_mask_reg;
      tc2_irq_pkg::async_addr: begin
        rdata_next[tc2_irq_pkg::busy_bits-1:0] = busy;
        rdata_next[tc2_irq_pkg::bit_async_sel] = async_ctl_reg[1];
        rdata_next[tc2_irq_pkg::bit_ext_clk] = async_ctl_reg[0];
      end
      tc2_irq_pkg::cmp_a_addr: rdata_next = slot_val[tc2_irq_pkg::bit_cmp_a_busy];
      tc2_irq_pkg::cmp_b_addr: rdata_next = slot_val[tc2_irq_pkg::bit_cmp_b_busy];
      tc2_irq_pkg::ctrl_a_addr: rdata_next = slot_val[tc2_irq_pkg::bit_ctrl_a_busy];
      tc2_irq_pkg::ctrl_b_addr: rdata_next = slot_val[tc2_irq_pkg::bit_ctrl_b_busy];
      // live count is read from the counter core, not from this holding copy
      tc2_irq_pkg::counter_addr: rdata_next = tc2_irq_pkg::reg_reset;
      default: rdata_next = tc2_irq_pkg::reg_reset;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= tc2_irq_pkg::reg_reset;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end
  end
endmodule : tc2_irq_status

// >>> test/tc2_irq_status_checker.sv
// checker: request gating, flag and async-update relations at the block ports
// assumes a bind onto tc2_irq_status with three interrupt sources
`timescale 1ns/1ps
module tc2_irq_status_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic io_space,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic global_irq_enable,
  input wire logic [7:0] counter_value,
  input wire logic counter_overflow,
  input wire logic pwm_mode,
  input wire logic pwm_bottom_turn,
  input wire logic [2:0] vector_ack,
  input wire logic [2:0] irq_req,
  input wire logic cmp_b_match,
  input wire logic ext_clock_input_enable,
  input wire logic crystal_osc_run,
  input wire logic timer_clk_async,
  input wire logic [7:0] compare_a_value,
  input wire logic [7:0] compare_b_value,
  input wire logic [7:0] counter_load_value,
  input wire logic counter_load
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic [7:0] eff = io_space ? 8'(addr + tc2_irq_pkg::io_space_offset) : addr;
  wire logic flag_wr = wr_en && eff == tc2_irq_pkg::flags_data_addr;
  wire logic mask_wr = wr_en && eff == tc2_irq_pkg::mask_addr;
  wire logic a_wr = wr_en && eff == tc2_irq_pkg::cmp_a_addr;
  wire logic cnt_wr = wr_en && eff == tc2_irq_pkg::counter_addr;
  // overflow source follows the mode, as the counter core reports it
  wire logic ovf_src = pwm_mode ? pwm_bottom_turn : counter_overflow;
  property p_gate; irq_req != 3'h0 |-> $past(global_irq_enable); endproperty
  a_gate: assert property (p_gate) else $error("request without global enable");
  // compare_b_value trails the live compare copy by one cycle, hence the past count
  property p_match; cmp_b_match == ($past(counter_value) == compare_b_value); endproperty
  a_match: assert property (p_match) else $error("compare b match missed");
  property p_ext; ext_clock_input_enable |-> timer_clk_async && !crystal_osc_run; endproperty
  a_ext: assert property (p_ext) else $error("external clock with crystal running");
  property p_vec; vector_ack[0] && !ovf_src |=> !irq_req[0]; endproperty
  a_vec: assert property (p_vec) else $error("vector did not clear overflow");
  property p_w1c; flag_wr && wdata[1] && counter_value != compare_a_value |=> !irq_req[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");
  property p_keep; irq_req[0] && global_irq_enable && ovf_src && !$past(mask_wr) |=> irq_req[0];
  endproperty
  a_keep: assert property (p_keep) else $error("overflow set lost");
  property p_bset;
    counter_value == compare_b_value && irq_req[2] && global_irq_enable && !$past(mask_wr)
      |=> irq_req[2];
  endproperty
  a_bset: assert property (p_bset) else $error("compare b set lost");
  property p_async;
    a_wr && timer_clk_async |-> ##5 compare_a_value == $past(wdata, 5);
  endproperty
  a_async: assert property (p_async) else $error("async compare a not loaded");
  property p_cload;
    cnt_wr && timer_clk_async |-> ##5 counter_load && counter_load_value == $past(wdata, 5);
  endproperty
  a_cload: assert property (p_cload) else $error("async counter value not handed over");
  c_irq: cover property (irq_req[2]);
  c_async: cover property (a_wr && timer_clk_async);
  c_pwm: cover property (pwm_mode && pwm_bottom_turn);
endmodule : tc2_irq_status_checker
bind tc2_irq_status tc2_irq_status_checker tc2_irq_status_checker_inst (.clk_sys, .resetn,
  .addr, .io_space, .wr_en, .wdata, .global_irq_enable, .counter_value, .counter_overflow,
  .pwm_mode, .pwm_bottom_turn, .vector_ack, .irq_req, .cmp_b_match, .ext_clock_input_enable,
  .crystal_osc_run, .timer_clk_async, .compare_a_value, .compare_b_value, .counter_load_value,
  .counter_load);

// >>> test/test_tc2_irq_status.sv
// testbench: register-port stimulus, queued read expectations checked by a monitor
// assumes tc2_irq_status with its bound checker, 25 MHz clock
`timescale 1ns/1ps
module test_tc2_irq_status;
  logic clk_sys = '0, resetn = '0, io_space = '0, wr_en = '0, rd_en = '0, rd_seen = '0;
  logic global_irq_enable = '0, counter_overflow = '0, pwm_mode = '0, pwm_bottom_turn = '0;
  logic [7:0] addr = '0, wdata = '0, counter_value = 8'h55, rdata, v, b;
  logic [2:0] vector_ack = '0, irq_req;
  logic [7:0] exp_q[$];
  logic [7:0] regs[4] = '{8'h37, 8'h70, 8'hb6, 8'h50};
  // status bit of each slot at 0xb0..0xb4: ctrl a, ctrl b, counter, cmp a, cmp b
  logic [7:0] busy_bit[5] = '{8'h02, 8'h01, 8'h10, 8'h08, 8'h04};
  logic [7:0] vals[5];
  int failures = 0, samples_checked = 0, seed = 70, i;
  always #20 clk_sys = ~clk_sys;
  tc2_irq_status tc2_irq_status_inst (.clk_sys, .resetn, .addr, .io_space, .wr_en, .rd_en,
    .wdata, .rdata, .global_irq_enable, .counter_value, .counter_overflow, .pwm_mode,
    .pwm_bottom_turn, .vector_ack, .irq_req, .cmp_b_match(), .ext_clock_input_enable(),
    .crystal_osc_run(), .timer_clk_async(), .compare_a_value(), .compare_b_value(),
    .timer_ctrl_a(), .timer_ctrl_b(), .counter_load_value(), .counter_load());
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected rdata: expected %h seen %h", exp, seen);
    end
  endtask : check
  // two cycles per access so a strobe is never lowered and raised in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk_sys);
    wr_en <= 1'h0;
    rd_en <= 1'h0;
    io_space <= 1'h0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'h0, a, 8'h00);
  endtask : rd
  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_sys) begin
    rd_seen <= rd_en;
    if (rd_seen) check(rdata, exp_q.pop_front());
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    for (i = 0; i < 4; i++) rd(regs[i], 8'h00);
    v = $random(seed);
    bus(1'h1, 8'h70, v);
    rd(8'h70, v & 8'h07);
    bus(1'h1, 8'h70, 8'h07);
    global_irq_enable <= 1'h1;
    counter_overflow <= 1'h1;
    @(posedge clk_sys);
    counter_overflow <= 1'h0;
    rd(8'h37, 8'h01);
    bus(1'h1, 8'h37, 8'h06);
    rd(8'h37, 8'h01);
    io_space <= 1'h1;
    bus(1'h1, 8'h17, 8'h01);
    rd(8'h37, 8'h00);
    pwm_mode <= 1'h1;
    pwm_bottom_turn <= 1'h1;
    repeat (2) @(posedge clk_sys);
    pwm_bottom_turn <= 1'h0;
    rd(8'h37, 8'h01);
    vector_ack <= 3'h1;
    @(posedge clk_sys);
    vector_ack <= 3'h0;
    pwm_mode <= 1'h0;
    rd(8'h37, 8'h00);
    for (i = 0; i < 2; i++) begin
      b = 8'h02 << i;
      bus(1'h1, 8'hb3 + b[2:1] - 8'h01, 8'h55);
      rd(8'h37, b);
      bus(1'h1, 8'h37, b);
      rd(8'h37, b);
      vector_ack <= b[2:0];
      @(posedge clk_sys);
      vector_ack <= 3'h0;
      bus(1'h1, 8'hb3 + b[2:1] - 8'h01, 8'h00);
      bus(1'h1, 8'h37, b);
      rd(8'h37, 8'h00);
    end
    bus(1'h1, 8'hb6, 8'h40);
    bus(1'h1, 8'hb6, 8'h7f);
    rd(8'hb6, 8'h60);
    for (i = 0; i < 5; i++) begin
      vals[i] = 8'($random(seed));
      bus(1'h1, 8'hb0 + i[7:0], vals[i]);
      rd(8'hb6, 8'h60 | busy_bit[i]);
      repeat (4) @(posedge clk_sys);
      rd(8'hb6, 8'h60);
    end
    // the counter slot reads zero here; the others return the handed-over value
    for (i = 0; i < 5; i++) begin
      rd(8'hb0 + i[7:0], (i == 2) ? 8'h00 : vals[i]);
    end
    repeat (3) @(posedge clk_sys);
    report_and_stop();
  end
endmodule : test_tc2_irq_status
